// file: include/twm_pkg.sv
// Purpose: shared constants and types for the two-wire master transmitter
// Assumes: 25 MHz mclk, AXI4-Lite register access, open-drain bus pins
// Notes: status codes carry zeros in the prescaler bits
package twm_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_STAT = 32'h0000_0004;
  localparam logic [31:0] OFS_DATA = 32'h0000_0008;

  // ----------------------------------------
  // bus_control_reg fields
  // ----------------------------------------
  localparam int CTL_DONE = 7;
  localparam int CTL_ACKEN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IRQEN = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'hF5;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------
  // bus_status_reg fields and codes
  // ----------------------------------------
  localparam int STA_PRE_LSB = 0;
  localparam logic [7:0] STA_CODE_MASK = 8'hF8;
  localparam logic [1:0] STA_PRE_RESET = 2'h0;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_REP = 8'h10;
  localparam logic [7:0] CODE_AW_ACK = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_D_ACK = 8'h28;
  localparam logic [7:0] CODE_D_NACK = 8'h30;
  localparam logic [7:0] CODE_LOST = 8'h38;
  localparam logic [7:0] CODE_AR_ACK = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_IDLE = 8'hF8;
  localparam logic [7:0] DATA_RESET = 8'hFF;

  // ----------------------------------------
  // AXI responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------
  // timing: one link bit is four quarter phases
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int QUARTER_CYC = LINK_PERIOD_NS / (4 * MCLK_PERIOD_NS);
  localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYC - 1);

  typedef enum logic [2:0] {
    ENG_IDLE, ENG_WAITFREE, ENG_START, ENG_HOLD, ENG_BIT, ENG_ACK, ENG_STOP
  } twm_eng_e;

  typedef enum logic [1:0] {SEL_CTRL, SEL_STAT, SEL_DATA, SEL_NONE} twm_sel_e;

endpackage

// file: rtl/twm_pin_sync.sv
// Purpose: two-flop synchroniser for the scl and sda pin levels
// Assumes: pins are asynchronous to mclk
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module twm_pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] pinIn,
  output logic [1:0] pinSync
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } twm_sync_s;

  twm_sync_s r;
  twm_sync_s n;

  always_comb begin
    n = r;
    n.meta = pinIn;
    n.stable = r.meta;
  end

  // idle bus lines are high, so reset to the released level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{meta: 2'h3, stable: 2'h3};
    end else begin
      r <= n;
    end
  end

  assign pinSync = r.stable;

endmodule

// file: rtl/twm_master.sv
// Purpose: two-wire bus master transmitter with AXI4-Lite registers
// Assumes: open-drain scl/sda, single master clock mclk
// Notes: master receive data phase is not built; read address only flags it
//
// Notes on behaviour
// [RL1] master mode only after start; direction picks mode
// [RL2] status codes compared with prescaler masked
// [RL3] software starts with done, start, enable set
// [RL4] start generated once the bus is free
// [RL5] after start: done flag, code 0x08
// [RL6] software loads write address then resumes
// [RL7] after address ack: done flag, 0x18/0x20/0x38
// [RL8] address ack gives 0x18, nack 0x20
// [RL9] software writes data only while done set
// [RL10] data write while busy: ignored, collision flag
// [RL11] data byte ack gives 0x28, nack 0x30
// [RL12] software requests stop with stop bit
// [RL13] software requests repeated start with start bit
// [RL14] repeated start reports 0x10, keeps bus
// [RL15] 0x08/0x10 resume sends loaded address
// [RL16] after byte states, start/stop pick next step
// [RL17] stop request bit cleared when stop sent
// [RL18] lost arbitration: 0x38, then release bus
// [RL19] lost with start set: wait free, restart
// [RL20] software keeps enable set in every write
// [RL21] transfer suspended while done flag set
// [RL22] interrupt when done flag and irq enable
`timescale 1ns/100ps
module twm_master (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic stepIrq,
  output logic masterRxMode
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    twm_pkg::twm_eng_e st;
    logic [1:0] ph;
    logic [2:0] bitIdx;
    logic [7:0] shift;
    logic [3:0] tickCnt;
    logic sclLow;
    logic sdaLow;
    logic busBusy;
    logic sclPrev;
    logic sdaPrev;
    logic master;
    logic rxMode;
    logic addrPh;
    logic ackLow;
    logic [7:0] ctrl;
    logic [7:0] data;
    logic [7:0] code;
    logic [1:0] presc;
    logic awHeld;
    twm_pkg::twm_sel_e awSel;
    logic wHeld;
    logic [7:0] wData;
    logic wLane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } twm_state_s;

  twm_state_s r;
  twm_state_s n;
  logic [1:0] pinSync;
  logic sclS;
  logic sdaS;
  logic tick;
  logic doWrite;
  logic resume;

  twm_pin_sync i_twm_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn({sclIn, sdaIn}),
    .pinSync(pinSync)
  );

  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  function automatic twm_pkg::twm_sel_e decodeAddr(input logic [31:0] a);
    twm_pkg::twm_sel_e s;
    s = twm_pkg::SEL_NONE;
    if (a == twm_pkg::OFS_CTRL) begin
      s = twm_pkg::SEL_CTRL;
    end else if (a == twm_pkg::OFS_STAT) begin
      s = twm_pkg::SEL_STAT;
    end else if (a == twm_pkg::OFS_DATA) begin
      s = twm_pkg::SEL_DATA;
    end
    return s;
  endfunction

  function automatic logic [7:0] readMux(input twm_state_s s, input twm_pkg::twm_sel_e sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      twm_pkg::SEL_CTRL: v = s.ctrl;
      // [RL2] prescaler in low bits
      twm_pkg::SEL_STAT: v = (s.code & twm_pkg::STA_CODE_MASK) | {6'h00, s.presc};
      twm_pkg::SEL_DATA: v = s.data;
      twm_pkg::SEL_NONE: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    tick = (r.tickCnt == twm_pkg::QUARTER_LAST);
    doWrite = r.awHeld && r.wHeld && !r.bvalid;
    // [RL21] engine waits until done flag cleared
    resume = (r.st == twm_pkg::ENG_HOLD) && !r.ctrl[twm_pkg::CTL_DONE];
    n.tickCnt = tick ? 4'h0 : r.tickCnt + 4'h1;

    // bus monitor on synchronised levels
    n.sclPrev = sclS;
    n.sdaPrev = sdaS;
    if (r.sclPrev && sclS && r.sdaPrev && !sdaS) begin
      n.busBusy = 1'b1;
    end else if (r.sclPrev && sclS && !r.sdaPrev && sdaS) begin
      n.busBusy = 1'b0;
    end

    // AXI write channel: address and data in either order
    if (awvalid && !r.awHeld) begin
      n.awHeld = 1'b1;
      n.awSel = decodeAddr(awaddr);
    end
    if (wvalid && !r.wHeld) begin
      n.wHeld = 1'b1;
      n.wData = wdata[7:0];
      n.wLane = wstrb[0];
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (doWrite) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (r.awSel == twm_pkg::SEL_NONE) ? twm_pkg::RESP_DECERR : twm_pkg::RESP_OKAY;
      if (r.wLane) begin
        unique case (r.awSel)
          twm_pkg::SEL_CTRL: begin
            n.ctrl = (r.wData & twm_pkg::CTL_WR_MASK) | (r.ctrl & ~twm_pkg::CTL_WR_MASK);
            // writing one clears the done flag, zero leaves it
            n.ctrl[twm_pkg::CTL_DONE] = r.ctrl[twm_pkg::CTL_DONE] && !r.wData[twm_pkg::CTL_DONE];
          end
          twm_pkg::SEL_STAT: n.presc = r.wData[twm_pkg::STA_PRE_LSB +: 2];
          twm_pkg::SEL_DATA: begin
            // [RL10] collision on busy write
            if (r.ctrl[twm_pkg::CTL_DONE]) begin
              n.data = r.wData;
              n.ctrl[twm_pkg::CTL_WCOL] = 1'b0;
            end else begin
              n.ctrl[twm_pkg::CTL_WCOL] = 1'b1;
            end
          end
          twm_pkg::SEL_NONE: n.presc = r.presc;
        endcase
      end
    end

    // AXI read channel: one cycle answer
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata = readMux(r, decodeAddr(araddr));
      n.rresp = (decodeAddr(araddr) == twm_pkg::SEL_NONE) ? twm_pkg::RESP_DECERR :
                twm_pkg::RESP_OKAY;
    end

    // ----------------------------------------
    // bus engine; flag sets below win over a clear above
    // ----------------------------------------
    if (!r.ctrl[twm_pkg::CTL_EN]) begin
      n.st = twm_pkg::ENG_IDLE;
      n.sclLow = 1'b0;
      n.sdaLow = 1'b0;
      n.master = 1'b0;
      n.rxMode = 1'b0;
    end else begin
      unique case (r.st)
        twm_pkg::ENG_IDLE: begin
          n.sclLow = 1'b0;
          n.sdaLow = 1'b0;
          // [RL1] master only through a start
          if (r.ctrl[twm_pkg::CTL_START] && !r.ctrl[twm_pkg::CTL_DONE]) begin
            n.st = twm_pkg::ENG_WAITFREE;
          end
        end
        twm_pkg::ENG_WAITFREE: begin
          // [RL4] start once bus free
          if (!r.busBusy && tick) begin
            n.st = twm_pkg::ENG_START;
            n.ph = 2'h0;
          end
        end
        twm_pkg::ENG_START: begin
          if (tick) begin
            unique case (r.ph)
              2'h0: begin
                n.sdaLow = 1'b0;
                n.ph = 2'h1;
              end
              2'h1: begin
                n.sclLow = 1'b0;
                n.ph = 2'h2;
              end
              2'h2: begin
                // a slave holding scl low stretches the phase
                if (sclS) begin
                  n.sdaLow = 1'b1;
                  n.ph = 2'h3;
                end
              end
              2'h3: begin
                n.sclLow = 1'b1;
                n.st = twm_pkg::ENG_HOLD;
                n.ctrl[twm_pkg::CTL_DONE] = 1'b1;
                // [RL5] first start code
                // [RL14] repeated start keeps bus
                n.code = r.master ? twm_pkg::CODE_REP : twm_pkg::CODE_START;
                n.master = 1'b1;
                n.rxMode = 1'b0;
              end
            endcase
          end
        end
        twm_pkg::ENG_HOLD: begin
          if (resume) begin
            if (!r.master) begin
              // [RL18] lost: release and stay unaddressed
              // [RL19] lost with start: retry later
              n.st = r.ctrl[twm_pkg::CTL_START] ? twm_pkg::ENG_WAITFREE : twm_pkg::ENG_IDLE;
              n.sclLow = 1'b0;
              n.sdaLow = 1'b0;
            end else if (r.ctrl[twm_pkg::CTL_STOP]) begin
              // [RL16] stop, or stop then start
              n.st = twm_pkg::ENG_STOP;
              n.ph = 2'h0;
            end else if (r.ctrl[twm_pkg::CTL_START]) begin
              // [RL16] repeated start request
              n.st = twm_pkg::ENG_START;
              n.ph = 2'h0;
            end else begin
              // [RL15] address after start codes
              // [RL16] next byte otherwise
              n.addrPh = (r.code == twm_pkg::CODE_START) || (r.code == twm_pkg::CODE_REP);
              if (n.addrPh) begin
                n.rxMode = r.data[0];
              end
              n.shift = r.data;
              n.bitIdx = 3'h7;
              n.st = twm_pkg::ENG_BIT;
              n.ph = 2'h0;
            end
          end
        end
        twm_pkg::ENG_BIT: begin
          if (tick) begin
            unique case (r.ph)
              2'h0: begin
                n.sdaLow = !r.shift[7];
                n.ph = 2'h1;
              end
              2'h1: begin
                n.sclLow = 1'b0;
                n.ph = 2'h2;
              end
              2'h2: begin
                if (sclS) begin
                  if (r.shift[7] && !sdaS) begin
                    // [RL18] lost arbitration
                    n.sclLow = 1'b0;
                    n.sdaLow = 1'b0;
                    n.master = 1'b0;
                    n.rxMode = 1'b0;
                    n.code = twm_pkg::CODE_LOST;
                    n.ctrl[twm_pkg::CTL_DONE] = 1'b1;
                    n.st = twm_pkg::ENG_HOLD;
                  end else begin
                    n.ph = 2'h3;
                  end
                end
              end
              2'h3: begin
                n.sclLow = 1'b1;
                n.shift = {r.shift[6:0], 1'b0};
                n.bitIdx = r.bitIdx - 3'h1;
                n.ph = 2'h0;
                if (r.bitIdx == 3'h0) begin
                  n.st = twm_pkg::ENG_ACK;
                end
              end
            endcase
          end
        end
        twm_pkg::ENG_ACK: begin
          if (tick) begin
            unique case (r.ph)
              2'h0: begin
                n.sdaLow = 1'b0;
                n.ph = 2'h1;
              end
              2'h1: begin
                n.sclLow = 1'b0;
                n.ph = 2'h2;
              end
              2'h2: begin
                if (sclS) begin
                  n.ackLow = !sdaS;
                  n.ph = 2'h3;
                end
              end
              2'h3: begin
                n.sclLow = 1'b1;
                n.ctrl[twm_pkg::CTL_DONE] = 1'b1;
                n.st = twm_pkg::ENG_HOLD;
                n.addrPh = 1'b0;
                // [RL7] address step done
                // [RL8] address ack or nack
                // [RL11] data ack or nack
                if (r.addrPh && r.rxMode) begin
                  n.code = r.ackLow ? twm_pkg::CODE_AR_ACK : twm_pkg::CODE_AR_NACK;
                end else if (r.addrPh) begin
                  n.code = r.ackLow ? twm_pkg::CODE_AW_ACK : twm_pkg::CODE_AW_NACK;
                end else begin
                  n.code = r.ackLow ? twm_pkg::CODE_D_ACK : twm_pkg::CODE_D_NACK;
                end
              end
            endcase
          end
        end
        twm_pkg::ENG_STOP: begin
          if (tick) begin
            unique case (r.ph)
              2'h0: begin
                n.sdaLow = 1'b1;
                n.ph = 2'h1;
              end
              2'h1: begin
                n.sclLow = 1'b0;
                n.ph = 2'h2;
              end
              2'h2: begin
                if (sclS) begin
                  n.sdaLow = 1'b0;
                  n.ph = 2'h3;
                end
              end
              2'h3: begin
                // [RL17] stop request self-clears
                n.ctrl[twm_pkg::CTL_STOP] = 1'b0;
                n.master = 1'b0;
                n.rxMode = 1'b0;
                n.code = twm_pkg::CODE_IDLE;
                n.st = r.ctrl[twm_pkg::CTL_START] ? twm_pkg::ENG_WAITFREE : twm_pkg::ENG_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: twm_pkg::ENG_IDLE, ph: 2'h0, bitIdx: 3'h0, shift: 8'h00, tickCnt: 4'h0,
             sclLow: 1'b0, sdaLow: 1'b0, busBusy: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1,
             master: 1'b0, rxMode: 1'b0, addrPh: 1'b0, ackLow: 1'b0,
             ctrl: twm_pkg::CTL_RESET, data: twm_pkg::DATA_RESET, code: twm_pkg::CODE_IDLE,
             presc: twm_pkg::STA_PRE_RESET, awHeld: 1'b0, awSel: twm_pkg::SEL_NONE,
             wHeld: 1'b0, wData: 8'h00, wLane: 1'b0, bvalid: 1'b0, bresp: 2'h0,
             rvalid: 1'b0, rdata: 8'h00, rresp: 2'h0};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready = !r.awHeld;
  assign wready = !r.wHeld;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = !r.rvalid;
  assign rvalid = r.rvalid;
  assign rdata = {24'h000000, r.rdata};
  assign rresp = r.rresp;
  // open drain: only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = r.sclLow;
  assign sdaOe = r.sdaLow;
  // [RL22] step interrupt
  assign stepIrq = r.ctrl[twm_pkg::CTL_DONE] && r.ctrl[twm_pkg::CTL_IRQEN];
  assign masterRxMode = r.rxMode;

endmodule

// file: tb/twm_slave_model.sv
// Purpose: behavioural slave receiver on the open-drain bus
// Assumes: bus levels already resolved with pull-ups
// Notes: loseArb mimics a second master pulling sda in data bits
`timescale 1ns/100ps
module twm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ackOn,
  input wire logic loseArb,
  output logic sdaOe,
  output logic [7:0] lastByte,
  output int startCnt,
  output int stopCnt
);
  logic [7:0] shiftR = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic ackOe = 1'b0;
  // lines settle from unknown to high before reset; that is no bus condition
  logic armed = 1'b0;
  initial begin
    lastByte = 8'h00;
    startCnt = 0;
    stopCnt = 0;
    #100 armed = 1'b1;
  end
  always @(negedge sda) if (scl && armed) begin
    startCnt++;
    cnt = 4'h0;
  end
  always @(posedge sda) if (scl && armed) begin
    stopCnt++;
    cnt = 4'h0;
  end
  // msb first, ninth clock is the ack slot
  always @(posedge scl) begin
    if (cnt < 4'h8) shiftR = {shiftR[6:0], sda};
    else lastByte = shiftR;
    cnt = (cnt < 4'h8) ? cnt + 4'h1 : 4'h0;
  end
  // ack changes only while scl is low
  always @(negedge scl) ackOe = ackOn && cnt == 4'h8;
  assign sdaOe = ackOe || (loseArb && cnt < 4'h8);
endmodule

// file: tb/twm_master_props.sv
// Purpose: port checker for twm_master
// Assumes: single mclk domain
// Notes: sees top ports only
`timescale 1ns/100ps
module twm_master_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic arready,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic stepIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_b_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b dropped");
  chk_r_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("r dropped");
  chk_ar_block:
    assert property (rvalid |-> !arready) else $error("ar taken during r");
  chk_rdata_byte:
    assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("rdata high bits");
  chk_resp_code:
    assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h3) else $error("bad bresp");
  chk_od_low:
    assert property (!sclOut && !sdaOut) else $error("pin driven high");
  chk_susp_hold:
    assert property (stepIrq && $past(stepIrq) |-> $stable(sclOe) && $stable(sdaOe))
    else $error("bus moved while done");
  // a quarter phase lasts two clocks, stretching only lengthens it
  chk_scl_phase:
    assert property ($changed(sclOe) |=> $stable(sclOe)) else $error("scl phase short");
  chk_stop_noflag:
    assert property ($fell(sdaOe) && !sclOe |-> !stepIrq) else $error("flag on stop");
endmodule
bind twm_master twm_master_props i_twm_master_props (.mclk, .rst_n, .bresp, .bvalid,
  .bready, .rdata, .rresp, .rvalid, .rready, .arready, .sclOut, .sclOe, .sdaOut, .sdaOe,
  .stepIrq);

// file: tb/twm_master_bench.sv
// Purpose: register-level bench for twm_master
// Assumes: one slave model on an open-drain bus
// Notes: step status codes compared with prescaler masked
`timescale 1ns/100ps
module twm_master_bench;
  localparam logic [31:0] CT = twm_pkg::OFS_CTRL;
  localparam logic [31:0] ST = twm_pkg::OFS_STAT;
  localparam logic [31:0] DT = twm_pkg::OFS_DATA;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sclOut, sclOe, sdaOut, sdaOe;
  logic stepIrq, masterRxMode, slvOe, ackOn = 1'b1, loseArb = 1'b0;
  logic [1:0] bresp, rresp;
  logic [7:0] lastByte;
  int startCnt, stopCnt, nErrors = 0, testsRun = 0, cyc = 0;
  wire sclW = sclOe ? sclOut : 1'b1;
  wire sdaW = (sdaOe ? sdaOut : 1'b1) & !slvOe;
  always #20 mclk = ~mclk;
  twm_master i_twm_master (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .sclIn(sclW), .sclOut, .sclOe, .sdaIn(sdaW), .sdaOut, .sdaOe,
    .stepIrq, .masterRxMode);
  twm_slave_model i_twm_slave_model (.scl(sclW), .sda(sdaW), .ackOn, .loseArb,
    .sdaOe(slvOe), .lastByte, .startCnt, .stopCnt);
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmpData(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // requests are checked before the edge, so the take is the next rising edge
  task automatic axiWr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ta, tw, tb, fin;
    fin = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      fin = tb;
    end
  endtask
  task automatic axiRd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr, fin;
    fin = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      fin = tr;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic [1:0] r;
    axiWr(a, {24'h0, v}, r);
    cmpResp(r, twm_pkg::RESP_OKAY);
  endtask
  task automatic rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(a, d, r);
    cmpResp(r, twm_pkg::RESP_OKAY);
    cmpData(d & m, e);
  endtask
  // polling is bounded by the cycle ceiling below
  task automatic waitBit(input int idx, input logic v);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    d[idx] = ~v;
    while (d[idx] !== v) axiRd(CT, d, r);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    wr(CT, c);
    waitBit(twm_pkg::CTL_DONE, 1'b1);
    rdChk(ST, 32'hF8, {24'h0, code});
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nErrors++;
      close_out();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdChk(CT, 32'hFF, 32'h00);
    rdChk(ST, 32'hFF, 32'hF8);
    wr(ST, 8'h03);
    rdChk(ST, 32'hFF, 32'hFB);
    rdChk(DT, 32'hFF, 32'hFF);
    axiRd(32'h0000_000C, d, r);
    cmpResp(r, twm_pkg::RESP_DECERR);
    axiWr(32'h0000_000C, 32'h0, r);
    cmpResp(r, twm_pkg::RESP_DECERR);
    $display("reset and map test done");
    step(8'hA4, twm_pkg::CODE_START);
    cmpData({31'h0, stepIrq}, 32'h0);
    cmpData(32'(startCnt), 32'h1);
    wr(DT, 8'hA0);
    wr(CT, 8'h85);
    wr(DT, 8'h55);
    waitBit(twm_pkg::CTL_DONE, 1'b1);
    rdChk(ST, 32'hF8, {24'h0, twm_pkg::CODE_AW_ACK});
    rdChk(CT, 32'h08, 32'h08);
    cmpData({24'h0, lastByte}, 32'hA0);
    rdChk(DT, 32'hFF, 32'hA0);
    cmpData({31'h0, stepIrq}, 32'h1);
    cmpData({31'h0, masterRxMode}, 32'h0);
    $display("start and address test done");
    wr(DT, 8'h3C);
    rdChk(CT, 32'h08, 32'h00);
    step(8'h85, twm_pkg::CODE_D_ACK);
    cmpData({24'h0, lastByte}, 32'h3C);
    repeat (60) @(negedge mclk);
    cmpData({31'h0, sclOe}, 32'h1);
    ackOn <= 1'b0;
    wr(DT, 8'hC3);
    step(8'h85, twm_pkg::CODE_D_NACK);
    cmpData({24'h0, lastByte}, 32'hC3);
    $display("data test done");
    step(8'hA5, twm_pkg::CODE_REP);
    cmpData(32'(stopCnt), 32'h0);
    wr(DT, 8'hA0);
    step(8'h85, twm_pkg::CODE_AW_NACK);
    step(8'hB5, twm_pkg::CODE_START);
    cmpData(32'(stopCnt), 32'h1);
    cmpData(32'(startCnt), 32'h3);
    $display("repeated start test done");
    ackOn <= 1'b1;
    wr(DT, 8'hA0);
    step(8'h85, twm_pkg::CODE_AW_ACK);
    wr(CT, 8'h95);
    waitBit(twm_pkg::CTL_STOP, 1'b0);
    rdChk(CT, 32'h90, 32'h00);
    rdChk(ST, 32'hFF, 32'hFB);
    cmpData(32'(stopCnt), 32'h2);
    $display("stop test done");
    step(8'hA5, twm_pkg::CODE_START);
    loseArb <= 1'b1;
    wr(DT, 8'hA0);
    step(8'h85, twm_pkg::CODE_LOST);
    cmpData({30'h0, sclOe, sdaOe}, 32'h0);
    loseArb <= 1'b0;
    step(8'hA5, twm_pkg::CODE_START);
    cmpData(32'(startCnt), 32'h5);
    wr(DT, 8'hA1);
    step(8'h85, twm_pkg::CODE_AR_ACK);
    cmpData({31'h0, masterRxMode}, 32'h1);
    $display("arbitration and read address test done");
    close_out();
  end
endmodule
